// File: hdl/qbx_defines.svh
// Constants shared by both ends of the port expander link
`ifndef QBX_DEFINES_SVH
`define QBX_DEFINES_SVH

// Fixed upper nibble of the seven-bit slave address
`define QBX_ADDR_HI        4'h7
// Port latch value after reset
`define QBX_PORT_RESET     8'hff
// Bit counts on the wire
`define QBX_BYTE_BITS      4'h8
`define QBX_FRAME_LAST     5'h11
`define QBX_ADDR_ACK_IDX   5'h08
// Timing
`define QBX_CLK_PERIOD_NS  10
`define QBX_SCL_PERIOD_NS  10000
`define QBX_SCL_QUARTER    (`QBX_SCL_PERIOD_NS / (4 * `QBX_CLK_PERIOD_NS))
`define QBX_ALERT_VALID_DELAY_NS 4000

`endif

// File: hdl/qbx_pkg.sv
// Types shared by both ends of the port expander link
package qbx_pkg;

  typedef enum logic [2:0] {
    ds_idle,
    ds_addr,
    ds_addr_ack,
    ds_write,
    ds_write_ack,
    ds_read,
    ds_read_ack,
    ds_ignore
  } qbx_dev_state_e;

  typedef enum logic [1:0] {
    ms_idle,
    ms_start,
    ms_bit,
    ms_stop
  } qbx_mst_state_e;

endpackage

// File: hdl/qbx_if.sv
// Two-wire bus and alert line joining master and expander
`timescale 1ns/1ps
interface qbx_if;
  logic scl;
  logic sda_mst_o;
  logic sda_mst_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda;
  logic alert_o;
  logic alert_oe;
  logic alert_n;

  // Wired-AND with pull-up: released lines read high
  assign sda     = !((sda_mst_oe && !sda_mst_o) || (sda_dev_oe && !sda_dev_o));
  assign alert_n = !(alert_oe && !alert_o);

  modport dev (
    input  scl,
    input  sda,
    output sda_dev_o,
    output sda_dev_oe,
    output alert_o,
    output alert_oe
  );

  modport mst (
    output scl,
    output sda_mst_o,
    output sda_mst_oe,
    input  sda,
    input  alert_n
  );
endinterface

// File: hdl/qbx_device.sv
// Expander end: two-wire slave, quasi-bidirectional port and alert
`timescale 1ns/1ps
`include "qbx_defines.svh"

module qbx_device (
  input  wire logic       link_clk,
  input  wire logic       link_rst,
  qbx_if.dev              bus,
  input  wire logic [2:0] address_strap_pins,
  input  wire logic [7:0] port_pins_i,
  output logic      [7:0] port_pins_o,
  output logic      [7:0] port_pins_oe
);

  logic [1:0]             scl_sy;
  logic [1:0]             sda_sy;
  logic                   scl_d;
  logic                   sda_d;
  logic [7:0]             port_sy0;
  logic [7:0]             port_s;
  logic [2:0]             strap_sy0;
  logic [2:0]             strap_s;
  logic                   scl_s;
  logic                   sda_s;
  logic                   start_ev;
  logic                   stop_ev;
  logic                   scl_rise;
  logic                   scl_fall;
  qbx_pkg::qbx_dev_state_e state;
  logic [3:0]             bitcnt;
  logic [7:0]             shreg;
  logic [2:0]             strap_lat;
  logic                   rw;
  logic                   wr_done;
  logic                   mst_ack;
  logic                   sda_low;
  logic [7:0]             latch;
  logic [7:0]             boost;
  logic [7:0]             ref_lvl;
  logic                   alert_q;
  logic                   clear_ev;

  // Two flops before anything reads the pins
  always_ff @(posedge link_clk) begin
    scl_sy    <= {scl_sy[0], bus.scl};
    sda_sy    <= {sda_sy[0], bus.sda};
    port_sy0  <= port_pins_i;
    port_s    <= port_sy0;
    strap_sy0 <= address_strap_pins;
    strap_s   <= strap_sy0;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_s    = scl_sy[1];
  assign sda_s    = sda_sy[1];
  // Bus conditions from the synchronised levels only
  assign start_ev = scl_s && scl_d && sda_d && !sda_s;
  assign stop_ev  = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state     <= qbx_pkg::ds_idle;
      bitcnt    <= 4'h0;
      shreg     <= 8'h00;
      strap_lat <= 3'h0;
      rw        <= 1'b0;
      wr_done   <= 1'b0;
      mst_ack   <= 1'b0;
      sda_low   <= 1'b0;
    end else if (stop_ev) begin
      state   <= qbx_pkg::ds_idle;
      sda_low <= 1'b0;
    end else if (start_ev) begin
      // Repeated start also lands here and restarts the address phase
      state     <= qbx_pkg::ds_addr;
      bitcnt    <= 4'h0;
      wr_done   <= 1'b0;
      sda_low   <= 1'b0;
      strap_lat <= strap_s;
    end else begin
      case (state)
        qbx_pkg::ds_addr: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == `QBX_BYTE_BITS) begin
            bitcnt <= 4'h0;
            // General call has a zero upper nibble and never matches
            if (shreg[7:1] == {`QBX_ADDR_HI, strap_lat}) begin
              sda_low <= 1'b1;
              rw      <= shreg[0];
              state   <= qbx_pkg::ds_addr_ack;
            end else begin
              state <= qbx_pkg::ds_ignore;
            end
          end
        end
        qbx_pkg::ds_addr_ack: begin
          if (scl_fall) begin
            if (rw) begin
              shreg   <= port_s;
              sda_low <= !port_s[7];
              state   <= qbx_pkg::ds_read;
            end else begin
              sda_low <= 1'b0;
              state   <= qbx_pkg::ds_write;
            end
            bitcnt <= 4'h0;
          end
        end
        qbx_pkg::ds_write: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == `QBX_BYTE_BITS) begin
            bitcnt <= 4'h0;
            if (!wr_done) begin
              sda_low <= 1'b1;
              state   <= qbx_pkg::ds_write_ack;
            end else begin
              state <= qbx_pkg::ds_ignore;
            end
          end
        end
        qbx_pkg::ds_write_ack: begin
          if (scl_fall) begin
            sda_low <= 1'b0;
            wr_done <= 1'b1;
            state   <= qbx_pkg::ds_write;
          end
        end
        qbx_pkg::ds_read: begin
          if (scl_fall) begin
            if (bitcnt == `QBX_BYTE_BITS - 4'h1) begin
              sda_low <= 1'b0;
              bitcnt  <= 4'h0;
              state   <= qbx_pkg::ds_read_ack;
            end else begin
              sda_low <= !shreg[6];
              shreg   <= {shreg[6:0], 1'b0};
              bitcnt  <= bitcnt + 4'h1;
            end
          end
        end
        qbx_pkg::ds_read_ack: begin
          if (scl_rise) begin
            mst_ack <= !sda_s;
          end else if (scl_fall) begin
            // Master ack asks for another fresh sample of the port
            if (mst_ack) begin
              shreg   <= port_s;
              sda_low <= !port_s[7];
              state   <= qbx_pkg::ds_read;
            end else begin
              state <= qbx_pkg::ds_ignore;
            end
          end
        end
        qbx_pkg::ds_ignore: begin
          sda_low <= 1'b0;
        end
        default: begin
          state   <= qbx_pkg::ds_idle;
          sda_low <= 1'b0;
        end
      endcase
    end
  end

  // Port latch: only a complete, acknowledged first byte reaches it
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      latch <= `QBX_PORT_RESET;
      boost <= 8'h00;
    end else if (state == qbx_pkg::ds_write_ack && scl_rise &&
                 !wr_done && !start_ev && !stop_ev) begin
      latch <= shreg;
      boost <= shreg;
    end else if (scl_fall) begin
      boost <= 8'h00;
    end
  end

  // Strong drive low for a zero, brief strong drive high after a write
  assign port_pins_o  = latch;
  assign port_pins_oe = ~latch | boost;

  // Alert compares the pins against the levels seen at the last clear
  assign clear_ev = !start_ev && !stop_ev &&
                    ((state == qbx_pkg::ds_addr_ack && rw && scl_rise) ||
                     (state == qbx_pkg::ds_write_ack && scl_fall));

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ref_lvl <= `QBX_PORT_RESET;
      alert_q <= 1'b0;
    end else if (clear_ev) begin
      // A change in this very cycle is absorbed into the new reference
      ref_lvl <= port_s;
      alert_q <= 1'b0;
    end else begin
      alert_q <= (port_s != ref_lvl);
    end
  end

  assign bus.sda_dev_o  = 1'b0;
  assign bus.sda_dev_oe = sda_low;
  assign bus.alert_o    = 1'b0;
  assign bus.alert_oe   = alert_q;

endmodule // qbx_device

// File: hdl/qbx_master.sv
// Bus master end: one-byte write or read transfers on the two-wire bus
`timescale 1ns/1ps
`include "qbx_defines.svh"

module qbx_master #(
  parameter int QUARTER = `QBX_SCL_QUARTER
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  qbx_if.mst              bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic [6:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            rsp_valid,
  output logic            rsp_nack,
  output logic      [7:0] rsp_rdata,
  output logic            alert
);

  logic [15:0]            qcnt;
  logic                   tick;
  logic [1:0]             sda_sy;
  logic [1:0]             alert_sy;
  qbx_pkg::qbx_mst_state_e state;
  logic [1:0]             phase;
  logic [4:0]             idx;
  logic [17:0]            frame;
  logic [17:0]            rx;
  logic                   rd;
  logic                   scl_q;
  logic                   sda_q;

  // Divider: the bus clock is made here, four ticks per bit
  assign tick = (qcnt == 16'(QUARTER - 1));

  always_ff @(posedge mclk) begin
    if (srst) begin
      qcnt <= 16'h0000;
    end else if (tick) begin
      qcnt <= 16'h0000;
    end else begin
      qcnt <= qcnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    sda_sy   <= {sda_sy[0], bus.sda};
    alert_sy <= {alert_sy[0], !bus.alert_n};
  end

  assign alert     = alert_sy[1];
  assign cmd_ready = (state == qbx_pkg::ms_idle);

  always_ff @(posedge mclk) begin
    if (srst) begin
      state     <= qbx_pkg::ms_idle;
      phase     <= 2'h0;
      idx       <= 5'h00;
      frame     <= 18'h3ffff;
      rx        <= 18'h00000;
      rd        <= 1'b0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_nack  <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        qbx_pkg::ms_idle: begin
          if (cmd_valid) begin
            // Ack slots are released; a read ends its byte with a nack
            frame <= {cmd_addr, cmd_read, 1'b1,
                      cmd_read ? 8'hff : cmd_wdata, 1'b1};
            rd    <= cmd_read;
            phase <= 2'h0;
            state <= qbx_pkg::ms_start;
          end
        end
        qbx_pkg::ms_start: begin
          if (tick) begin
            phase <= phase + 2'h1;
            if (phase == 2'h0) begin
              sda_q <= 1'b0;
            end else if (phase == 2'h1) begin
              scl_q <= 1'b0;
              idx   <= 5'h00;
              phase <= 2'h0;
              state <= qbx_pkg::ms_bit;
            end
          end
        end
        qbx_pkg::ms_bit: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: begin
                sda_q <= frame[17];
                frame <= {frame[16:0], 1'b1};
              end
              2'h1: scl_q <= 1'b1;
              2'h2: rx <= {rx[16:0], sda_sy[1]};
              default: begin
                scl_q <= 1'b0;
                idx   <= idx + 5'h01;
                if ((idx == `QBX_ADDR_ACK_IDX && rx[0]) ||
                    idx == `QBX_FRAME_LAST) begin
                  rsp_nack <= rx[0] &&
                              (idx == `QBX_ADDR_ACK_IDX || !rd);
                  state    <= qbx_pkg::ms_stop;
                end
              end
            endcase
          end
        end
        qbx_pkg::ms_stop: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sda_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b1;
              default: begin
                rsp_rdata <= rx[8:1];
                rsp_valid <= 1'b1;
                state     <= qbx_pkg::ms_idle;
              end
            endcase
          end
        end
        default: state <= qbx_pkg::ms_idle;
      endcase
    end
  end

  assign bus.scl        = scl_q;
  assign bus.sda_mst_o  = 1'b0;
  assign bus.sda_mst_oe = !sda_q;

endmodule // qbx_master

// File: verif/qbx_props.sv
// Concurrent checks on the expander side of the link
`timescale 1ns/1ps
module qbx_props (
  input wire logic       link_clk,
  input wire logic       link_rst,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       sda_dev_o,
  input wire logic       sda_dev_oe,
  input wire logic       alert_o,
  input wire logic       alert_oe,
  input wire logic [7:0] port_pins_i,
  input wire logic [7:0] port_pins_o,
  input wire logic [7:0] port_pins_oe
);
  default clocking @(posedge link_clk); endclocking
  default disable iff (link_rst);
  // Windows span the worst synchroniser delay of an async edge
  sequence scl_low_run;
    (!scl)[*6];
  endsequence
  sequence pins_moved;
    $past(port_pins_i, 1) != $past(port_pins_i, 7);
  endsequence
  sequence scl_moved;
    $past(scl, 1) != $past(scl, 8);
  endsequence
  reset_vals_a: assert property (
    $fell(link_rst) |-> port_pins_o == 8'hff && port_pins_oe == 8'h00
      && !alert_oe && !sda_dev_oe)
    else $error("expander outputs wrong after reset");
  dev_pull_low_a: assert property (sda_dev_oe |-> !sda_dev_o)
    else $error("expander drives data high");
  alert_pull_a: assert property (alert_oe |-> !alert_o)
    else $error("alert driven high");
  dev_scl_low_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("expander data changed while clock high");
  dev_no_cond_a: assert property (
    scl && $changed(sda) |-> !sda_dev_oe)
    else $error("expander drove a start or stop");
  latch_scl_hi_a: assert property ($changed(port_pins_o) |-> scl)
    else $error("latch moved while clock low");
  boost_load_a: assert property (
    $changed(port_pins_o) |=> port_pins_oe == 8'hff)
    else $error("written ones not boosted");
  boost_end_a: assert property (
    scl_low_run |-> port_pins_oe == ~port_pins_o)
    else $error("boost kept past clock fall");
  alert_set_a: assert property ($rose(alert_oe) |-> pins_moved)
    else $error("alert raised without pin change");
  alert_clr_a: assert property (
    $fell(alert_oe) |-> pins_moved or scl_moved)
    else $error("alert cleared without cause");
endmodule // qbx_props

// File: verif/tb_i2c_quasi_bidir_io_expander.sv
// Bench joining the bus master and the expander on one link
`timescale 1ns/1ps
`include "qbx_defines.svh"
module tb_i2c_quasi_bidir_io_expander;
  localparam int QUARTER = 10;
  logic       mclk      = 1'b0;
  logic       link_clk  = 1'b0;
  logic       srst      = 1'b1;
  logic       link_rst  = 1'b1;
  logic       cmd_valid = 1'b0;
  logic       cmd_read  = 1'b0;
  logic [6:0] cmd_addr  = 7'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [2:0] straps    = 3'h0;
  logic [7:0] ext_en    = 8'h00;
  logic [7:0] ext_val   = 8'h00;
  logic       cmd_ready;
  logic       rsp_valid;
  logic       rsp_nack;
  logic [7:0] rsp_rdata;
  logic       alert;
  logic [7:0] pins_o;
  logic [7:0] pins_oe;
  logic [7:0] pins;
  int         mismatches      = 0;
  int         samples_checked = 0;

  qbx_if qbx_if_inst ();
  // Weak pull-up: an undriven pin reads high
  assign pins = (pins_oe & pins_o) | (~pins_oe & (ext_val | ~ext_en));

  qbx_master #(.QUARTER(QUARTER)) qbx_master_inst (
    .mclk(mclk), .srst(srst), .bus(qbx_if_inst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
    .rsp_rdata(rsp_rdata), .alert(alert));
  qbx_device qbx_device_inst (
    .link_clk(link_clk), .link_rst(link_rst), .bus(qbx_if_inst),
    .address_strap_pins(straps), .port_pins_i(pins),
    .port_pins_o(pins_o), .port_pins_oe(pins_oe));
  qbx_props qbx_props_inst (
    .link_clk(link_clk), .link_rst(link_rst), .scl(qbx_if_inst.scl),
    .sda(qbx_if_inst.sda), .sda_dev_o(qbx_if_inst.sda_dev_o),
    .sda_dev_oe(qbx_if_inst.sda_dev_oe), .alert_o(qbx_if_inst.alert_o),
    .alert_oe(qbx_if_inst.alert_oe), .port_pins_i(pins),
    .port_pins_o(pins_o), .port_pins_oe(pins_oe));

  initial begin
    forever #5 mclk = ~mclk;
  end
  // Odd offset keeps the link clock out of phase with mclk
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  task automatic give_verdict;
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic settle;
    repeat (20) @(posedge mclk);
    #1;
  endtask

  task automatic xfer(input logic rd, input logic [6:0] addr,
                      input logic [7:0] wd);
    int n;
    n = 0;
    cmd_read = rd;
    cmd_addr = addr;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 2000) mismatches++;
  endtask

  task automatic t_power;
    check("latch", pins_o, 8'hff);
    check("alert", {7'h0, alert}, 8'h00);
  endtask

  task automatic t_addr;
    logic [7:0] v;
    for (int s = 0; s < 8; s++) begin
      v = {5'h00, 3'(s)} ^ 8'h5c;
      straps = 3'(s);
      xfer(1'b0, {`QBX_ADDR_HI, 3'(s)}, v);
      check("ack", {7'h0, rsp_nack}, 8'h00);
      check("latch", pins_o, v);
      xfer(1'b0, {`QBX_ADDR_HI, 3'(s) ^ 3'h4}, 8'h00);
      check("nack", {7'h0, rsp_nack}, 8'h01);
      check("kept", pins_o, v);
    end
    xfer(1'b0, 7'h00, 8'h00);
    check("gcall", {7'h0, rsp_nack}, 8'h01);
    check("kept", pins_o, 8'h5b);
    xfer(1'b0, 7'h3f, 8'hff);
    check("latch", pins_o, 8'hff);
  endtask

  task automatic t_alert;
    ext_val = 8'h5a;
    ext_en = 8'hff;
    settle;
    check("alert", {7'h0, alert}, 8'h01);
    ext_en = 8'h00;
    settle;
    check("alert", {7'h0, alert}, 8'h00);
    ext_en = 8'hff;
    settle;
    check("alert", {7'h0, alert}, 8'h01);
    xfer(1'b0, 7'h3b, 8'h00);
    check("other", {7'h0, alert}, 8'h01);
    xfer(1'b1, 7'h3f, 8'h00);
    check("rdata", rsp_rdata, 8'h5a);
    settle;
    check("alert", {7'h0, alert}, 8'h00);
    ext_en = 8'h00;
    settle;
    check("alert", {7'h0, alert}, 8'h01);
    xfer(1'b0, 7'h3f, 8'hff);
    settle;
    check("alert", {7'h0, alert}, 8'h00);
  endtask

  // Whole run is about 13000 mclk cycles
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge mclk);
    #1;
    srst = 1'b0;
    link_rst = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    t_power();
    t_addr();
    t_alert();
    give_verdict();
  end
endmodule // tb_i2c_quasi_bidir_io_expander
